// *** msc_params.svh ***
// Constants for the mimic symbol control block
// What this block does
// - Two-output controlled symbol has separate open and close control outputs.
// - Each accepted order on two-output symbol gives one 300 ms pulse if that output is idle.
// - Single-output symbol holds its output until the next accepted order.
// - Each accepted order on single-output symbol inverts its output.
// - Two inhibit inputs; either at 1 blocks open and close orders.
// - Two-input symbol: only open input set is open, only closed is closed.
// - Two-input symbol with equal inputs reports unknown.
// - Single-input symbol: input 0 inactive, input 1 active.
// - Graphic refreshes automatically whenever decoded state changes.
// - Fixed symbol has no inputs, outputs or orders.
// - Animated-only symbol follows inputs but refuses orders.
// - Diagram drawn over fixed 128 by 240 pixel background.
// - Local, remote, test key positions may feed inputs and disable operation.
// - Breaker close blocked status may feed input and disable operation.
// - Control outputs route to logic outputs, switchgear control or equations.
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH
`define MSC_CLK_HZ 20000000
`define MSC_PULSE_MS 300
`define MSC_PULSE_CYC ((`MSC_CLK_HZ / 1000) * `MSC_PULSE_MS)
`define MSC_BG_W 128
`define MSC_BG_H 240
`define MSC_ADDR_KIND 4'h0
`define MSC_ADDR_CFG 4'h1
`define MSC_ADDR_STATE 4'h2
`define MSC_ADDR_GFX 4'h3
`define MSC_ADDR_BG 4'h4
`define MSC_KIND_RST 2'h0
`define MSC_CFG_RST 8'h00
`define MSC_CFG_LOCAL_BIT 0
`define MSC_CFG_REMOTE_BIT 1
`define MSC_CFG_TEST_BIT 2
`define MSC_CFG_BRK_BIT 3
`endif

// *** msc_pkg.sv ***
// Types for the mimic symbol control block
`default_nettype none
package msc_pkg;
  typedef enum logic [1:0] {
    MSC_KIND_FIXED = 2'h0,
    MSC_KIND_ANIM = 2'h1,
    MSC_KIND_CTRL = 2'h2
  } msc_kind_t;
  typedef enum logic [1:0] {
    MSC_ST_OPEN = 2'h0,
    MSC_ST_CLOSED = 2'h1,
    MSC_ST_UNKNOWN = 2'h2
  } msc_state_t;
  typedef struct packed {
    logic open_cmd;
    logic close_cmd;
    logic toggle_out;
  } msc_ctrl_t;
  typedef struct packed {
    logic inhibit_a;
    logic inhibit_b;
  } msc_inh_t;
endpackage
`default_nettype wire

// *** msc_pulse.sv ***
// Fixed-width pulse generator for one control output
`default_nettype none
module msc_pulse #(
  parameter int unsigned CYCLES = 6000000
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic start_i,
  output logic pulse_o
);
  localparam int unsigned W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_q;

  initial begin
    if (CYCLES < 1) $error("msc_pulse: CYCLES must be at least 1");
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      pulse_o <= 1'b0;
    end else if (en_i) begin
      if (start_i && !pulse_o) begin
        cnt_q <= W'(CYCLES - 1);
        pulse_o <= 1'b1;
      end else if (pulse_o) begin
        if (cnt_q == '0) begin
          pulse_o <= 1'b0;
        end else begin
          cnt_q <= cnt_q - W'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** msc_symbol.sv ***
// Mimic symbol decode and local control top
//
// Added by the designer: the strobed register port and the placing of the registers.
`include "msc_params.svh"
`default_nettype none
module msc_symbol #(
  parameter int unsigned PULSE_CYC = `MSC_PULSE_CYC,
  parameter int unsigned BG_W = `MSC_BG_W,
  parameter int unsigned BG_H = `MSC_BG_H
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic pos_open_i,
  input wire logic pos_closed_i,
  input wire msc_pkg::msc_inh_t inhibit_i,
  input wire logic key_local_i,
  input wire logic key_remote_i,
  input wire logic key_test_i,
  input wire logic breaker_close_blocked_i,
  input wire logic order_open_i,
  input wire logic order_close_i,
  output msc_pkg::msc_ctrl_t ctrl_o,
  output msc_pkg::msc_state_t state_o,
  output logic [1:0] graphic_o,
  output logic graphic_refresh_o
);
  import msc_pkg::*;

  initial begin
    if (PULSE_CYC < 1) $error("msc_symbol: PULSE_CYC must be at least 1");
    if (BG_W != 128 || BG_H != 240) $error("msc_symbol: background must be 128 by 240");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic msc_state_t decode_two(input logic op, input logic cl);
    if (op && !cl) begin
      return MSC_ST_OPEN;
    end else if (!op && cl) begin
      return MSC_ST_CLOSED;
    end else begin
      return MSC_ST_UNKNOWN;
    end
  endfunction

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  msc_kind_t kind_q;
  logic two_io_q;
  logic [7:0] cfg_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kind_q <= MSC_KIND_FIXED;
      two_io_q <= 1'b1;
    end else if (ce_i && wr_i && addr_i == `MSC_ADDR_KIND) begin
      case (wdata_i[1:0])
        2'h1: kind_q <= MSC_KIND_ANIM;
        2'h2: kind_q <= MSC_KIND_CTRL;
        default: kind_q <= MSC_KIND_FIXED;
      endcase
      two_io_q <= wdata_i[4];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q <= `MSC_CFG_RST;
    end else if (ce_i && wr_i && addr_i == `MSC_ADDR_CFG) begin
      cfg_q <= wdata_i[7:0];
    end
  end

  // ----------------------------------------
  // State decode
  // ----------------------------------------
  msc_state_t state_d;
  logic [1:0] graphic_d;

  always_comb begin
    state_d = MSC_ST_UNKNOWN;
    graphic_d = 2'h0;
    case (kind_q)
      MSC_KIND_FIXED: begin
        state_d = MSC_ST_UNKNOWN;
        graphic_d = 2'h0;
      end
      MSC_KIND_ANIM, MSC_KIND_CTRL: begin
        if (two_io_q) begin
          state_d = decode_two(pos_open_i, pos_closed_i);
        end else begin
          state_d = pos_open_i ? MSC_ST_CLOSED : MSC_ST_OPEN;
        end
        graphic_d = state_d;
      end
      default: begin
        state_d = MSC_ST_UNKNOWN;
        graphic_d = 2'h0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_o <= MSC_ST_UNKNOWN;
      graphic_o <= 2'h0;
      graphic_refresh_o <= 1'b0;
    end else if (ce_i) begin
      state_o <= state_d;
      graphic_o <= graphic_d;
      graphic_refresh_o <= (state_d != state_o);
    end
  end

  // ----------------------------------------
  // Order gating
  // ----------------------------------------
  logic blocked;
  logic ord_open;
  logic ord_close;
  logic mode_block;

  // Key mode: when its cfg_q bit is set, a non-local, remote or test key position disables display orders
  assign mode_block = (cfg_q[`MSC_CFG_LOCAL_BIT] && !key_local_i)
                    || (cfg_q[`MSC_CFG_REMOTE_BIT] && key_remote_i)
                    || (cfg_q[`MSC_CFG_TEST_BIT] && key_test_i);
  assign blocked = inhibit_i.inhibit_a || inhibit_i.inhibit_b
                 || mode_block
                 || (cfg_q[`MSC_CFG_BRK_BIT] && breaker_close_blocked_i)
                 || kind_q != MSC_KIND_CTRL;
  // Blocked orders fall through here and leave no trace
  assign ord_open = order_open_i && !blocked;
  assign ord_close = order_close_i && !blocked;

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  logic open_pulse;
  logic close_pulse;

  msc_pulse #(.CYCLES(PULSE_CYC)) u_open (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(ce_i),
    .start_i(ord_open && two_io_q),
    .pulse_o(open_pulse)
  );

  msc_pulse #(.CYCLES(PULSE_CYC)) u_close (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(ce_i),
    .start_i(ord_close && two_io_q),
    .pulse_o(close_pulse)
  );

  logic toggle_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      toggle_q <= 1'b0;
    end else if (ce_i && !two_io_q && (ord_open || ord_close)) begin
      toggle_q <= ~toggle_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_o <= '0;
    end else if (ce_i) begin
      ctrl_o.open_cmd <= open_pulse;
      ctrl_o.close_cmd <= close_pulse;
      ctrl_o.toggle_out <= toggle_q;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 16'h0000;
    end else if (ce_i) begin
      if (rd_i) begin
        case (addr_i)
          `MSC_ADDR_KIND: rdata_o <= {11'h000, two_io_q, 2'h0, kind_q};
          `MSC_ADDR_CFG: rdata_o <= {8'h00, cfg_q};
          `MSC_ADDR_STATE: rdata_o <= {11'h000, blocked, toggle_q, close_pulse, state_o};
          `MSC_ADDR_GFX: rdata_o <= {14'h0000, graphic_o};
          `MSC_ADDR_BG: rdata_o <= {8'(BG_W), 8'(BG_H)};
          default: rdata_o <= 16'h0000;
        endcase
      end else begin
        rdata_o <= 16'h0000;
      end
    end
  end
endmodule
`default_nettype wire

// *** msc_monitor.sv ***
// Checker for the mimic symbol control block
`default_nettype none
module msc_monitor #(
  parameter int unsigned PULSE_CYC = 5
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic pos_open_i,
  input wire logic pos_closed_i,
  input wire msc_pkg::msc_inh_t inhibit_i,
  input wire logic key_local_i,
  input wire logic key_remote_i,
  input wire logic key_test_i,
  input wire logic breaker_close_blocked_i,
  input wire logic order_open_i,
  input wire logic order_close_i,
  input wire msc_pkg::msc_ctrl_t ctrl_o,
  input wire msc_pkg::msc_state_t state_o,
  input wire logic graphic_refresh_o
);
  import msc_pkg::*;
  logic [4:0] kind_q;
  logic [31:0] on_q;
  logic ct, an, two, ord, clr;
  assign ct = kind_q[1:0] == 2'h2;
  assign an = ct || kind_q[1:0] == 2'h1;
  assign two = an && kind_q[4];
  assign ord = order_open_i || order_close_i;
  assign clr = inhibit_i == 2'h0 && key_local_i && !key_remote_i && !key_test_i && !breaker_close_blocked_i;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kind_q <= 5'h10;
      on_q <= 32'h0;
    end else begin
      kind_q <= (wr_i && addr_i == 4'h0) ? wdata_i[4:0] : kind_q;
      on_q <= ctrl_o.open_cmd ? on_q + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_quiet;
    ##2 !$rose(ctrl_o.open_cmd) && !$rose(ctrl_o.close_cmd) && $stable(ctrl_o.toggle_out);
  endsequence
  property p_open;
    ct && kind_q[4] && clr && order_open_i && !ctrl_o.open_cmd && !$past(order_open_i) |-> ##2 $rose(ctrl_o.open_cmd);
  endproperty
  property p_wid; $fell(ctrl_o.open_cmd) |-> on_q == PULSE_CYC; endproperty
  property p_tog; $changed(ctrl_o.toggle_out) |-> $past(ord, 2); endproperty
  property p_ref; ord && (inhibit_i != 2'h0 || !ct) |-> s_quiet; endproperty
  property p_two; two && pos_open_i != pos_closed_i |=> state_o == {1'b0, $past(pos_closed_i)}; endproperty
  property p_unk; two && pos_open_i == pos_closed_i |=> state_o == MSC_ST_UNKNOWN; endproperty
  property p_one; an && !kind_q[4] |=> state_o == {1'b0, $past(pos_open_i)}; endproperty
  property p_gfx; $changed(state_o) |-> graphic_refresh_o; endproperty
  a_open: assert property (p_open) else $error("open order gave no pulse");
  a_wid: assert property (p_wid) else $error("pulse width wrong");
  a_tog: assert property (p_tog) else $error("toggle without order");
  a_ref: assert property (p_ref) else $error("refused order acted");
  a_two: assert property (p_two) else $error("open or closed decode wrong");
  a_unk: assert property (p_unk) else $error("unknown decode wrong");
  a_one: assert property (p_one) else $error("single input decode wrong");
  a_gfx: assert property (p_gfx) else $error("no graphic refresh");
endmodule
bind msc_symbol msc_monitor #(.PULSE_CYC(PULSE_CYC)) i_mon (.*);
`default_nettype wire

// *** msc_gear.sv ***
// Switchgear model behind the symbol control outputs
`default_nettype none
module msc_gear (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire msc_pkg::msc_ctrl_t ctrl_i,
  input wire logic stuck_i,
  output logic open_o,
  output logic closed_o
);
  import msc_pkg::*;
  logic shut_q;
  logic mv;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shut_q <= 1'b0;
    end else if (ctrl_i.open_cmd || ctrl_i.close_cmd) begin
      shut_q <= ctrl_i.close_cmd;
    end
  end
  // Both contacts drop while travelling, unless stuck_i holds both high
  assign mv = ctrl_i.open_cmd | ctrl_i.close_cmd;
  assign open_o = stuck_i | (!mv & (ctrl_i.toggle_out ^ !shut_q));
  assign closed_o = stuck_i | (!mv & shut_q);
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the mimic symbol control block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import msc_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, stuck = 1'b0;
  logic order_open_i = 1'b0, order_close_i = 1'b0, key_local_i = 1'b1, key_remote_i = 1'b0;
  logic key_test_i = 1'b0, breaker_close_blocked_i = 1'b0, pos_open_i, pos_closed_i, graphic_refresh_o;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000, rdata_o;
  logic [1:0] graphic_o;
  msc_inh_t inhibit_i = 2'h0;
  msc_ctrl_t ctrl_o;
  msc_state_t state_o;
  int failures = 0, cmp_count = 0, seed = 56980, r;
  logic [4:0] kd = 5'h10;
  always #25 clk_i = ~clk_i;
  msc_symbol #(.PULSE_CYC(5)) i_dut (.*);
  msc_gear i_gear (.clk_i(clk_i), .rst_n_i(rst_n_i), .ctrl_i(ctrl_o), .stuck_i(stuck), .open_o(pos_open_i),
    .closed_o(pos_closed_i));
  task automatic chk(input bit ok, input string s);
    cmp_count++;
    if (!ok) begin
      failures++;
      $display("MISMATCH %0t %s", $time, s);
    end
  endtask
  function automatic logic [1:0] exp_st(input logic [4:0] k, input logic op, input logic cl);
    if (k[1:0] != 2'h1 && k[1:0] != 2'h2) return 2'h2;
    if (!k[4]) return {1'b0, op};
    if (op == cl) return 2'h2;
    return {1'b0, cl};
  endfunction
  task automatic final_report();
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic bus(input bit w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    if (w && a == 4'h0) kd = d[4:0];
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    if (!w) begin
      #1 chk(rdata_o === d, "read data");
    end
  endtask
  task automatic go(input bit o, input msc_inh_t ib, input int w, input int t);
    int n, m;
    logic p;
    logic [1:0] e;
    n = 0;
    m = 0;
    p = ctrl_o.toggle_out;
    @(posedge clk_i);
    order_open_i <= o;
    order_close_i <= !o;
    inhibit_i <= ib;
    @(posedge clk_i);
    order_open_i <= 1'b0;
    order_close_i <= 1'b0;
    repeat (12) begin
      @(negedge clk_i);
      n += int'((o ? ctrl_o.open_cmd : ctrl_o.close_cmd) === 1'b1);
      m += int'(ctrl_o.toggle_out !== p);
      p = ctrl_o.toggle_out;
    end
    chk(n == w && m == t, "order response");
    e = exp_st(kd, pos_open_i, pos_closed_i);
    chk(state_o === e, "symbol state");
    chk(graphic_o === ((kd[1:0] == 2'h1 || kd[1:0] == 2'h2) ? e : 2'h0), "symbol graphic");
  endtask
  initial begin
    #200000;
    failures++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    bus(1'b0, 4'h4, 16'h80F0);
    bus(1'b0, 4'h9, 16'h0000);
    go(1'b1, 2'h0, 0, 0);
    bus(1'b1, 4'h0, 16'h0011);
    go(1'b0, 2'h0, 0, 0);
    bus(1'b1, 4'h0, 16'h0012);
    go(1'b1, 2'h0, 5, 0);
    go(1'b0, 2'h2, 0, 0);
    go(1'b0, 2'h1, 0, 0);
    go(1'b0, 2'h0, 5, 0);
    bus(1'b1, 4'h1, 16'h000E);
    key_remote_i <= 1'b1;
    go(1'b1, 2'h0, 0, 0);
    @(posedge clk_i);
    key_remote_i <= 1'b0;
    breaker_close_blocked_i <= 1'b1;
    go(1'b1, 2'h0, 0, 0);
    bus(1'b1, 4'h1, 16'h0000);
    breaker_close_blocked_i <= 1'b0;
    bus(1'b1, 4'h0, 16'h0002);
    go(1'b1, 2'h0, 0, 1);
    go(1'b0, 2'h0, 0, 1);
    go(1'b1, 2'h3, 0, 0);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 4'h0, {11'h000, ~k[0], 2'h0, k[1] ? 2'h1 : 2'h2});
      repeat (150) begin
        @(posedge clk_i);
        r = $random(seed);
        order_open_i <= r[2:0] == 3'h0;
        order_close_i <= r[2:0] == 3'h1;
        inhibit_i <= (r[6:3] == 4'h0) ? r[8:7] : 2'h0;
        stuck <= r[12:9] == 4'h0;
      end
      @(posedge clk_i);
      order_open_i <= 1'b0;
      order_close_i <= 1'b0;
      repeat (8) @(posedge clk_i);
    end
    final_report();
  end
endmodule
`default_nettype wire
